/* logic/spidp_pkg.sv */
// Shared constants for the byte-wide serial data path block.
// Assumes a 40 MHz core clock and an 8-bit AXI4-Lite byte address.
package spidp_pkg;
  // ----------------------------------------------------------------
  // Register indexes and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL1 = 8'h00;
  localparam logic [7:0] IDX_CTRL2 = 8'h01;
  localparam logic [7:0] IDX_STAT = 8'h03;
  localparam logic [7:0] IDX_DATA = 8'h05;
  localparam logic [7:0] IDX_MATCH = 8'h07;
  localparam logic [7:0] ADDR_CTRL1 = {IDX_CTRL1[5:0], 2'h0};
  localparam logic [7:0] ADDR_CTRL2 = {IDX_CTRL2[5:0], 2'h0};
  localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'h0};
  localparam logic [7:0] ADDR_DATA = {IDX_DATA[5:0], 2'h0};
  localparam logic [7:0] ADDR_MATCH = {IDX_MATCH[5:0], 2'h0};
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_EN = 6;
  localparam int C1_CONTROLLER_SELECT_BIT = 4;
  localparam int C1_CLOCK_POLARITY_BIT = 3;
  localparam int C1_CLOCK_PHASE_BIT = 2;
  localparam int C1_SELECT_OUTPUT_ENABLE = 1;
  localparam int C2_TXDMA = 5;
  localparam int C2_FDEN = 4;
  localparam int ST_RXF = 7;
  localparam int ST_MATCH = 6;
  localparam int ST_TXE = 5;
  localparam int ST_FAULT = 4;
  localparam logic [3:0] ST_RSVD = 4'h0;
  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int SCK_HALF_NS = 100;
  localparam int SCK_HALF_CYC_I = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC_I - 1);
  localparam logic [4:0] EDGE_LAST = 5'h0f;
  typedef enum {SPIDP_IDLE, SPIDP_RUN} spidp_state_e;
endpackage : spidp_pkg

/* logic/spidp_sync.sv */
// Two-flop synchroniser for the serial link pins.
// Assumes inputs are asynchronous to core_clk; output is the second flop.
`timescale 1ns/1ps
module spidp_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '1;
      sync_o <= '1;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : spidp_sync

/* logic/spidp_top.sv */
// Serial data path: registers over AXI4-Lite, byte shifter, pins.
// Assumes link pins are asynchronous; DMA done is on core_clk.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module spidp_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transmit DMA
  output logic tx_dma_req,
  input wire logic tx_dma_done,
  // Link pins
  input wire logic ss_b_i,
  output logic ss_b_o,
  output logic ss_b_oe,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl1_r, ctrl2_r, cmp_r, txbuf_r, rxbuf_r, sh_r, rx_byte;
  logic txbuf_full_r, txe_r, txe_arm_r, rxf_r, match_r, fault_r, fault_arm_r;
  logic aw_have_r, w_have_r, aw_have_nxt, w_have_nxt, bvalid_nxt, do_wr;
  logic [7:0] aw_addr_r, wa;
  logic [31:0] w_data_r, wd;
  logic [3:0] w_strb_r, ws;
  logic ar_take, rvalid_nxt, rd_stat, rd_data;
  logic wr_c1, wr_c2, wr_data, wr_match, wr_data_ok, abort;
  logic en, controller_select_bit, fault_cond, load, edge_ev, done, lat_r, phase_r, sck_prev_r;
  logic [3:0] pins_s;
  logic [3:0] div_r;
  logic [4:0] edge_cnt_r;
  logic [7:0] status_w;
  spidp_pkg::spidp_state_e state_r;

  // Is the byte address one of ours
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == spidp_pkg::ADDR_CTRL1) || (a == spidp_pkg::ADDR_CTRL2) ||
                (a == spidp_pkg::ADDR_STAT) || (a == spidp_pkg::ADDR_DATA) ||
                (a == spidp_pkg::ADDR_MATCH);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // Pin synchronisers: {ss, sck, mosi, miso}
  // ----------------------------------------------------------------
  spidp_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_i({ss_b_i, sck_i, mosi_i, miso_i}),
    .sync_o(pins_s)
  );

  assign en = ctrl1_r[spidp_pkg::C1_EN];
  assign controller_select_bit = ctrl1_r[spidp_pkg::C1_CONTROLLER_SELECT_BIT];
  assign fault_cond = en && controller_select_bit && ctrl2_r[spidp_pkg::C2_FDEN] &&
                      !ctrl1_r[spidp_pkg::C1_SELECT_OUTPUT_ENABLE] && !pins_s[3];
  // Reserved low nibble is a constant zero
  assign status_w = {rxf_r, match_r, txe_r, fault_r, spidp_pkg::ST_RSVD};

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; response after both
  always_comb begin
    wa = aw_have_r ? aw_addr_r : s_axi_awaddr;
    wd = w_have_r ? w_data_r : s_axi_wdata;
    ws = w_have_r ? w_strb_r : s_axi_wstrb;
    do_wr = (aw_have_r || (s_axi_awvalid && s_axi_awready)) &&
            (w_have_r || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
    aw_have_nxt = (aw_have_r || (s_axi_awvalid && s_axi_awready)) && !do_wr;
    w_have_nxt = (w_have_r || (s_axi_wvalid && s_axi_wready)) && !do_wr;
    bvalid_nxt = do_wr || (s_axi_bvalid && !s_axi_bready);
  end

  // Write channel flops; ready drops while a half is held or a reply waits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= spidp_pkg::BYTE_ZERO;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spidp_pkg::RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_have_nxt && !bvalid_nxt;
      s_axi_wready <= !w_have_nxt && !bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (do_wr) begin
        s_axi_bresp <= is_mapped(wa) ? spidp_pkg::RESP_OKAY : spidp_pkg::RESP_SLVERR;
      end
    end
  end

  // Write strobes; only byte lane 0 carries register data
  assign wr_c1 = do_wr && ws[0] && (wa == spidp_pkg::ADDR_CTRL1);
  assign wr_c2 = do_wr && ws[0] && (wa == spidp_pkg::ADDR_CTRL2);
  assign wr_data = do_wr && ws[0] && (wa == spidp_pkg::ADDR_DATA);
  assign wr_match = do_wr && ws[0] && (wa == spidp_pkg::ADDR_MATCH);
  assign wr_data_ok = wr_data && (ctrl2_r[spidp_pkg::C2_TXDMA] ? txe_r : txe_arm_r);
  // Changing format bits mid-transfer as master drops the byte
  assign abort = !en || fault_cond ||
                 (wr_c1 && controller_select_bit && (wd[spidp_pkg::C1_CLOCK_POLARITY_BIT:spidp_pkg::C1_SELECT_OUTPUT_ENABLE] !=
                                    ctrl1_r[spidp_pkg::C1_CLOCK_POLARITY_BIT:spidp_pkg::C1_SELECT_OUTPUT_ENABLE]));

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);
  assign rd_stat = ar_take && (s_axi_araddr == spidp_pkg::ADDR_STAT);
  assign rd_data = ar_take && (s_axi_araddr == spidp_pkg::ADDR_DATA);

  // Read data is captured at the address handshake, shown next cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= spidp_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (ar_take) begin
        s_axi_rresp <= is_mapped(s_axi_araddr) ? spidp_pkg::RESP_OKAY : spidp_pkg::RESP_SLVERR;
        case (s_axi_araddr)
          spidp_pkg::ADDR_CTRL1: s_axi_rdata <= {24'h000000, ctrl1_r};
          spidp_pkg::ADDR_CTRL2: s_axi_rdata <= {24'h000000, ctrl2_r};
          spidp_pkg::ADDR_STAT: s_axi_rdata <= {24'h000000, status_w};
          spidp_pkg::ADDR_DATA: s_axi_rdata <= {24'h000000, rxbuf_r};
          spidp_pkg::ADDR_MATCH: s_axi_rdata <= {24'h000000, cmp_r};
          default: s_axi_rdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // A fault forces slave mode; it wins over a same-cycle write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_r <= spidp_pkg::CTRL1_RST;
      ctrl2_r <= spidp_pkg::CTRL2_RST;
      cmp_r <= spidp_pkg::MATCH_RST;
    end else begin
      if (wr_c1) begin
        ctrl1_r <= wd[7:0];
      end
      if (fault_cond) begin
        ctrl1_r[spidp_pkg::C1_CONTROLLER_SELECT_BIT] <= 1'b0;
      end
      if (wr_c2) begin
        ctrl2_r <= wd[7:0];
      end
      if (wr_match) begin
        cmp_r <= wd[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer and empty flag
  // ----------------------------------------------------------------
  // Idle shifter takes the buffer at once so a second byte can queue
  assign load = en && (state_r == spidp_pkg::SPIDP_IDLE) && txbuf_full_r &&
                !(controller_select_bit && fault_cond);

  // Arm on status read with empty set, winning over a same-cycle data write; any other data write disarms
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txe_arm_r <= 1'b0;
    end else if (rd_stat && txe_r) begin
      txe_arm_r <= 1'b1;
    end else if (wr_data) begin
      txe_arm_r <= 1'b0;
    end
  end

  // Buffer contents; ignored writes leave it untouched
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txbuf_r <= spidp_pkg::BYTE_ZERO;
      txbuf_full_r <= 1'b0;
    end else begin
      if (wr_data_ok) begin
        txbuf_r <= wd[7:0];
        txbuf_full_r <= 1'b1;
      end else if (load) begin
        txbuf_full_r <= 1'b0;
      end
    end
  end

  // Empty flag: set on move into the shifter wins over any clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txe_r <= 1'b1;
    end else if (load) begin
      txe_r <= 1'b1;
    end else if (ctrl2_r[spidp_pkg::C2_TXDMA] ? tx_dma_done : wr_data_ok) begin
      txe_r <= 1'b0;
    end
  end

  // DMA request is level, recomputed each cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_dma_req <= 1'b0;
    end else begin
      tx_dma_req <= en && ctrl2_r[spidp_pkg::C2_TXDMA] && txe_r;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  // Master ticks every half period; slave reacts to any clock edge
  assign edge_ev = (state_r == spidp_pkg::SPIDP_RUN) &&
                   (controller_select_bit ? (div_r == spidp_pkg::SCK_HALF_LAST) : (pins_s[2] != sck_prev_r));
  assign done = edge_ev && (edge_cnt_r == spidp_pkg::EDGE_LAST) && !abort;
  // With phase set the last bit is sampled on the final edge itself
  assign rx_byte = ctrl1_r[spidp_pkg::C1_CLOCK_PHASE_BIT] ? {sh_r[6:0], (controller_select_bit ? pins_s[0] : pins_s[1])}
                                               : {sh_r[6:0], lat_r};

  // Edge numbering: edge_cnt_r counts edges already seen
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= spidp_pkg::SPIDP_IDLE;
      div_r <= 4'h0;
      edge_cnt_r <= 5'h00;
      phase_r <= 1'b0;
      lat_r <= 1'b0;
      sh_r <= spidp_pkg::BYTE_ZERO;
      sck_prev_r <= 1'b1;
    end else begin
      sck_prev_r <= pins_s[2];
      if (load) begin
        sh_r <= txbuf_r;
      end
      case (state_r)
        spidp_pkg::SPIDP_IDLE: begin
          div_r <= 4'h0;
          edge_cnt_r <= 5'h00;
          phase_r <= 1'b0;
          if (controller_select_bit ? load : (en && !pins_s[3])) begin
            state_r <= spidp_pkg::SPIDP_RUN;
          end
        end
        spidp_pkg::SPIDP_RUN: begin
          div_r <= (div_r == spidp_pkg::SCK_HALF_LAST) ? 4'h0 : div_r + 4'h1;
          if (abort || (!controller_select_bit && pins_s[3])) begin
            state_r <= spidp_pkg::SPIDP_IDLE;
          end else if (edge_ev) begin
            phase_r <= !phase_r;
            edge_cnt_r <= edge_cnt_r + 5'h01;
            if (!edge_cnt_r[0] ^ ctrl1_r[spidp_pkg::C1_CLOCK_PHASE_BIT]) begin
              lat_r <= controller_select_bit ? pins_s[0] : pins_s[1];
            end else if (!(ctrl1_r[spidp_pkg::C1_CLOCK_PHASE_BIT] && (edge_cnt_r == 5'h00))) begin
              sh_r <= {sh_r[6:0], lat_r};
            end
            if (done) begin
              state_r <= spidp_pkg::SPIDP_IDLE;
            end
          end
        end
        default: state_r <= spidp_pkg::SPIDP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer and flags
  // ----------------------------------------------------------------
  // Store only into an empty (or same-cycle drained) buffer; no overrun flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxbuf_r <= spidp_pkg::BYTE_ZERO;
      rxf_r <= 1'b0;
      match_r <= 1'b0;
    end else begin
      if (done && (!rxf_r || rd_data)) begin
        rxbuf_r <= rx_byte;
        rxf_r <= 1'b1;
      end else if (rd_data) begin
        rxf_r <= 1'b0;
      end
      if (done && (!rxf_r || rd_data) && (rx_byte == cmp_r)) begin
        match_r <= 1'b1;
      end else if (rd_stat && match_r) begin
        match_r <= 1'b0;
      end
    end
  end

  // Fault flag: clear needs a read at 1, then a control write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_r <= 1'b0;
      fault_arm_r <= 1'b0;
    end else begin
      if (fault_cond) begin
        fault_r <= 1'b1;
      end else if (wr_c1 && fault_arm_r) begin
        fault_r <= 1'b0;
      end
      if (rd_stat && fault_r) begin
        fault_arm_r <= 1'b1;
      end else if (wr_c1) begin
        fault_arm_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered
  // ----------------------------------------------------------------
  // Disabled block releases every pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      ss_b_o <= 1'b1;
      ss_b_oe <= 1'b0;
    end else begin
      sck_o <= ctrl1_r[spidp_pkg::C1_CLOCK_POLARITY_BIT] ^ phase_r;
      sck_oe <= en && controller_select_bit;
      mosi_o <= sh_r[7];
      mosi_oe <= en && controller_select_bit;
      miso_o <= sh_r[7];
      miso_oe <= en && !controller_select_bit && !pins_s[3];
      ss_b_o <= (state_r != spidp_pkg::SPIDP_RUN);
      ss_b_oe <= en && controller_select_bit && ctrl2_r[spidp_pkg::C2_FDEN] && ctrl1_r[spidp_pkg::C1_SELECT_OUTPUT_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fault_cause;
    @(posedge core_clk) disable iff (!rst_b) $rose(fault_r) |-> $past(fault_cond);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault flag without cause");
  property p_stat_rsvd;
    @(posedge core_clk) disable iff (!rst_b)
      rd_stat |=> (s_axi_rdata[3:0] == 4'h0) && (s_axi_rdata[7:4] == $past(status_w[7:4]));
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status read wrong");
  property p_wr_ignored;
    @(posedge core_clk) disable iff (!rst_b)
      wr_data && !ctrl2_r[spidp_pkg::C2_TXDMA] && !txe_arm_r |=> $stable(txbuf_r);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("unarmed write taken");
  property p_match;
    @(posedge core_clk) disable iff (!rst_b)
      done && !rxf_r && (rx_byte == cmp_r) |=> match_r && (rxbuf_r == cmp_r);
  endproperty
  a_match: assert property (p_match) else $error("compare hit missed");
  property p_overrun_keep;
    @(posedge core_clk) disable iff (!rst_b) done && rxf_r && !rd_data |=> $stable(rxbuf_r);
  endproperty
  a_overrun_keep: assert property (p_overrun_keep) else $error("old byte lost");
  property p_rxf_set;
    @(posedge core_clk) disable iff (!rst_b) done |=> rxf_r;
  endproperty
  a_rxf_set: assert property (p_rxf_set) else $error("receive full not set");
  property p_master_start;
    @(posedge core_clk) disable iff (!rst_b)
      load && controller_select_bit |=> (state_r == spidp_pkg::SPIDP_RUN) && txe_r ##1 !txbuf_full_r || txe_r;
  endproperty
  a_master_start: assert property (p_master_start) else $error("master did not start");
  property p_dma_req;
    @(posedge core_clk) disable iff (!rst_b)
      en && ctrl2_r[spidp_pkg::C2_TXDMA] && txe_r |=> tx_dma_req;
  endproperty
  a_dma_req: assert property (p_dma_req) else $error("dma request missing");
  c_master_done: cover property (@(posedge core_clk) disable iff (!rst_b) done && controller_select_bit);
  c_slave_done: cover property (@(posedge core_clk) disable iff (!rst_b) done && !controller_select_bit);
  c_fault: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(fault_r));
  c_overrun: cover property (@(posedge core_clk) disable iff (!rst_b) done && rxf_r);
endmodule : spidp_top

/* testbench/spidp_peer.sv */
// Far-side slave model for the serial link, one byte per frame.
// Assumes clock polarity 0 and phase 1: launch on rise, sample on fall.
`timescale 1ns/1ps
module spidp_peer (
  // Link
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Bench side
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output int frames
);
  int n = 0;
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    frames = 0;
  end
  // Odd edges launch the next bit, MSB first; odd frames send the inverse
  always @(posedge sck) begin
    if (n == 0) sh = tx_byte ^ {8{frames[0]}};
    miso = sh[7 - n];
  end
  // Even edges sample; between frames the line flips so nothing stale is held
  always @(negedge sck) begin
    rx_byte = {rx_byte[6:0], mosi};
    n = n + 1;
    if (n == 8) begin
      n = 0;
      frames = frames + 1;
      miso = ~miso;
    end
  end
endmodule : spidp_peer

/* testbench/tb.sv */
// Bench for the serial data path: register bus master and a link peer.
// Assumes the peer model beside it and a 40 MHz core clock.
`timescale 1ns/1ps
module tb;
  logic core_clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, tx_dma_req, ss_b_i = 1, ss_b_o, ss_b_oe;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
  logic tx_dma_done = 0, sck_i = 0, mosi_i = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pb = 0, seed = 8'h02, peer_rx;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] q[$];
  logic [33:0] exp_v;
  int n_errors = 0, comparisons = 0, peer_frames;
  spidp_top spidp_top_inst (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_dma_req, .tx_dma_done, .ss_b_i, .ss_b_o, .ss_b_oe,
    .sck_i, .sck_o, .sck_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe);
  spidp_peer spidp_peer_inst (.sck(sck_o), .mosi(mosi_o), .miso(miso_i), .tx_byte(pb),
    .rx_byte(peer_rx), .frames(peer_frames));
  // 25 ns clock
  always #12.5 core_clk = ~core_clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic tmo();
    n_errors++;
    complete_run();
  endtask : tmo
  task automatic chk(input logic [33:0] got, input logic [33:0] want);
    comparisons++;
    if (got !== want) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 50) tmo();
  endtask : wr
  // Read: the expected answer is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    int k;
    @(posedge core_clk);
    q.push_back({e[9:8], 24'h0, e[7:0]});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 50) tmo();
  endtask : rd
  // Settle a few cycles past the peer's last edge so store and reload land
  task automatic wait_frames(input int n);
    int k;
    for (k = 0; k < 400 && peer_frames != n; k++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    if (k == 400) tmo();
  endtask : wait_frames
  // Each read answer is matched with the oldest noted expectation
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      exp_v = q.pop_front();
      chk({s_axi_rresp, s_axi_rdata}, exp_v);
    end
  end
  // Main sequence
  initial begin
    pb = lfsr(seed);
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(spidp_pkg::ADDR_MATCH, 10'h000);
    rd(8'h08, 10'h200);
    wr(spidp_pkg::ADDR_CTRL1, 8'h54);
    @(negedge core_clk);
    chk(34'(sck_oe & mosi_oe), 34'h1);
    seed = lfsr(pb);
    wr(spidp_pkg::ADDR_DATA, seed);
    repeat (80) @(posedge core_clk);
    chk(34'(peer_frames), 34'h0);
    wr(spidp_pkg::ADDR_CTRL2, 8'h20);
    for (int k = 0; k < 8 && tx_dma_req !== 1'b1; k++) @(posedge core_clk);
    chk(34'(tx_dma_req), 34'h1);
    seed = lfsr(seed);
    wr(spidp_pkg::ADDR_DATA, seed);
    wait_frames(1);
    rd(spidp_pkg::ADDR_STAT, 10'h0a0);
    chk(34'(peer_rx), 34'(seed));
    rd(spidp_pkg::ADDR_DATA, {2'h0, pb});
    wr(spidp_pkg::ADDR_CTRL2, 8'h00);
    wr(spidp_pkg::ADDR_MATCH, ~pb);
    rd(spidp_pkg::ADDR_STAT, 10'h020);
    seed = lfsr(seed);
    wr(spidp_pkg::ADDR_DATA, seed);
    rd(spidp_pkg::ADDR_STAT, 10'h020);
    wr(spidp_pkg::ADDR_DATA, lfsr(seed));
    wait_frames(2);
    rd(spidp_pkg::ADDR_STAT, 10'h0e0);
    wait_frames(3);
    rd(spidp_pkg::ADDR_DATA, {2'h0, ~pb});
    rd(spidp_pkg::ADDR_STAT, 10'h020);
    chk(34'(peer_rx), 34'(lfsr(seed)));
    wr(spidp_pkg::ADDR_CTRL2, 8'h10);
    ss_b_i <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(spidp_pkg::ADDR_STAT, 10'h030);
    rd(spidp_pkg::ADDR_CTRL1, 10'h044);
    ss_b_i <= 1'b1;
    wr(spidp_pkg::ADDR_CTRL1, 8'h5c);
    rd(spidp_pkg::ADDR_STAT, 10'h020);
    chk(34'(sck_o), 34'h1);
    // Slave byte from the bench: 200 ns link clock, launch on rise, sample on fall
    wr(spidp_pkg::ADDR_CTRL1, 8'h44);
    ss_b_i <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(34'(miso_oe), 34'h1);
    pb = lfsr(lfsr(seed));
    for (int i = 7; i >= 0; i--) begin
      sck_i <= 1'b1;
      mosi_i <= pb[i];
      repeat (4) @(posedge core_clk);
      sck_i <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    ss_b_i <= 1'b1;
    rd(spidp_pkg::ADDR_DATA, {2'h0, pb});
    // DMA done while a byte is queued behind a running one leaves empty clear
    wr(spidp_pkg::ADDR_CTRL1, 8'h54);
    wr(spidp_pkg::ADDR_CTRL2, 8'h20);
    wr(spidp_pkg::ADDR_DATA, pb);
    wr(spidp_pkg::ADDR_DATA, seed);
    tx_dma_done <= 1'b1;
    @(posedge core_clk);
    tx_dma_done <= 1'b0;
    rd(spidp_pkg::ADDR_STAT, 10'h000);
    complete_run();
  end
endmodule : tb
